// file: hdl/swc_pkg.sv
// Package of the switch-input configuration block: command codes, field
// positions, power-on defaults, timing constants and shared types.
// Assumes a 100 MHz system clock; all design files import it whole.
package swc_pkg;

  // ****************************************************************
  // Sizes.
  // ****************************************************************
  localparam int NUM_SP  = 8;
  localparam int NUM_SG  = 14;
  localparam int NUM_IN  = 22;
  localparam int CMD_W   = 24;

  // ****************************************************************
  // Command codes in bits 23..16 and argument fields.
  // ****************************************************************
  localparam logic [7:0] CMD_ANALOG = 8'h06;
  localparam logic [7:0] CMD_TMR_SP = 8'h07;
  localparam logic [7:0] CMD_TMR_SG = 8'h08;
  localparam logic [7:0] CMD_HZ_SP  = 8'h09;
  localparam logic [7:0] CMD_HZ_SG  = 8'h0a;
  localparam logic [7:0] CMD_CAL    = 8'h0b;
  localparam logic [7:0] CMD_RESET  = 8'h7f;
  localparam int CUR_SEL_LSB = 5;
  localparam int CHAN_MSB    = 4;
  localparam logic [4:0] CHAN_LAST  = 5'h16;
  localparam logic [1:0] CUR_HZ     = 2'h0;
  localparam logic [1:0] CUR_2MA    = 2'h1;
  localparam logic [1:0] CUR_16MA   = 2'h2;

  // ****************************************************************
  // Power-on defaults.
  // ****************************************************************
  localparam logic [7:0]  RST_TMR_SP = 8'hff;
  localparam logic [13:0] RST_TMR_SG = 14'h3fff;
  localparam logic [7:0]  RST_HZ_SP  = 8'hff;
  localparam logic [13:0] RST_HZ_SG  = 14'h3fff;
  localparam logic [6:0]  RST_ANALOG = 7'h00;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int          CLK_MHZ       = 100;
  localparam int          WET_TIME_MS   = 20;
  localparam logic [14:0] WET_TIME_US   = 15'(WET_TIME_MS * 1000);
  localparam int          CAL_PULSE_US  = 512;
  localparam int          CAL_SHIFT     = $clog2(CAL_PULSE_US);
  localparam logic [15:0] TICK_CYCLES   = 16'(CLK_MHZ);

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] arg;
  } swc_cmd_t;

  typedef struct packed {
    logic [21:0] high_z;
    logic [21:0] cur_16ma;
    logic [21:0] cur_2ma;
    logic [7:0]  pull_up;
  } swc_drive_t;

  typedef enum logic [1:0] {
    CAL_IDLE    = 2'b00,
    CAL_ARMED   = 2'b01,
    CAL_MEASURE = 2'b10
  } swc_cal_state_t;

endpackage : swc_pkg

// file: hdl/swc_wet_timer.sv
// One wetting-current timer for a single switch input.
// Assumes a one-cycle time-base tick and a same-clock restart pulse.
`timescale 1ns/100ps
module swc_wet_timer
  import swc_pkg::*;
#(
  parameter logic [14:0] WET_TICKS = WET_TIME_US
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic restart,
  input  wire logic enable,
  output logic      expired
);

  logic [14:0] cnt;
  logic        running;

  // Counting starts on a threshold crossing; a disabled timer never expires.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= 15'h0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (!enable || restart) begin
      cnt     <= 15'h0000;
      running <= enable;
      expired <= 1'b0;
    end else if (tick && running) begin
      if (cnt == WET_TICKS - 15'h0001) begin
        running <= 1'b0;
        expired <= 1'b1;
      end else begin
        cnt <= cnt + 15'h0001;
      end
    end
  end

endmodule : swc_wet_timer

// file: hdl/swc_spi_link.sv
// Serial link end on the link clock: shifts 24-bit commands in, status out.
// Assumes the status word is held still while chip select is low.
`timescale 1ns/100ps
module swc_spi_link
  import swc_pkg::*;
(
  input  wire logic        spi_sclk,
  input  wire logic        sys_rst,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  input  wire logic [23:0] tx_word,
  output logic [23:0]      rx_word,
  output logic             rx_complete,
  output logic             frame_tgl,
  output logic             spi_so,
  output logic             spi_so_oe
);

  logic [4:0]  bit_cnt;
  logic [23:0] tx_shift;
  logic        fresh;
  wire         frame_rst = sys_rst | spi_cs_n;

  // Marks the first edge of a frame; set again by chip select or reset, so the
  // clock may stand still between frames.
  always_ff @(posedge spi_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Command bits enter MSB first; count and word stay put after the frame.
  always_ff @(posedge spi_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt   <= 5'h00;
      rx_word   <= 24'h000000;
      tx_shift  <= 24'h000000;
      frame_tgl <= 1'b0;
    end else begin
      rx_word  <= {rx_word[22:0], spi_mosi};
      tx_shift <= fresh ? {tx_word[22:0], 1'b0} : {tx_shift[22:0], 1'b0};
      if (fresh) begin
        bit_cnt   <= 5'h01;
        frame_tgl <= ~frame_tgl;
      end else if (bit_cnt != 5'h1f) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  assign rx_complete = (bit_cnt == 5'(CMD_W));
  assign spi_so      = fresh ? tx_word[23] : tx_shift[23];
  assign spi_so_oe   = ~spi_cs_n;

endmodule : swc_spi_link

// file: hdl/swc_top.sv
// Top of the switch-input configuration block: command decode, wetting
// timers, high-impedance and analog channel control, time-base trim.
// Assumes the link pins come from an outside master and that comparator,
// mode and supply levels are asynchronous to mclk.
//
// Operation
// - Each input owns a 20 ms wetting timer started by a threshold crossing.
// - An expired timer drops that input from 16 mA to 2 mA.
// - A disabled timer keeps the input at 16 mA without limit.
// - Enable bit 1 turns the input's timer on, 0 turns it off.
// - Timer enable commands decode by bits 23..16; eight and fourteen bit masks.
// - A set high-impedance bit floats any input but the analog channel, overriding the current level.
// - Comparators stay active while an input floats.
// - Two high-impedance commands carry masks for programmable and ground inputs.
// - One of 22 inputs is routed to the analog output pin.
// - The analog channel's bit reads 0 in the next status response.
// - Current select 00 floats, 01 gives 2 mA, 10 16 mA, 11 floats.
// - Analog mode currents are always pull-ups, never pull-downs.
// - Channel 0 selects none, 1..14 ground inputs, 15..22 programmable inputs.
// - After calibration, a 512 us chip-select low pulse trims the time base.
// - The reset command restores every programmable register to its default.
// - Defaults: timers on, all inputs floating, 16 mA, no analog channel.
// - Programming is accepted only in Normal mode with interface supply present.
`timescale 1ns/100ps
module swc_top
  import swc_pkg::*;
#(
  parameter logic [14:0] WET_TICKS = WET_TIME_US
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_so,
  output logic             spi_so_oe,
  input  wire logic        normal_mode,
  input  wire logic        vdd_present,
  input  wire logic [21:0] cmp_above,
  input  wire logic [7:0]  prog_to_battery,
  output swc_drive_t       drive,
  output logic [4:0]       analog_output_pin_sel,
  output logic             analog_output_pin_en,
  output logic [15:0]      time_base_trim
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [7:0]     timer_enable_programmable;
  logic [13:0]    timer_enable_ground;
  logic [7:0]     high_z_programmable;
  logic [13:0]    high_z_ground;
  logic [6:0]     analog_channel_select;
  logic [25:0]    sync1;
  logic [25:0]    sync2;
  logic [21:0]    cmp_prev;
  logic           cs_prev;
  logic           tgl_seen;
  logic [23:0]    status_word;
  logic [23:0]    rx_word;
  logic           rx_complete;
  logic           frame_tgl;
  logic [21:0]    wet_expired;
  logic [15:0]    tick_cnt;
  logic           us_tick;
  logic [23:0]    cal_cnt;
  swc_cal_state_t cal_state;
  swc_cal_state_t next_cal_state;

  // ****************************************************************
  // Link end on the link clock.
  // ****************************************************************
  swc_spi_link u_link (
    .spi_sclk    (spi_sclk),
    .sys_rst     (sys_rst),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .tx_word     (status_word),
    .rx_word     (rx_word),
    .rx_complete (rx_complete),
    .frame_tgl   (frame_tgl),
    .spi_so      (spi_so),
    .spi_so_oe   (spi_so_oe)
  );

  // ****************************************************************
  // Synchronisers for the comparator, chip-select, mode, supply and frame-toggle levels.
  // ****************************************************************

  // Two flops per bit: {comparators, chip select, mode, supply, frame toggle}.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= {22'h000000, 4'h8};
      sync2 <= {22'h000000, 4'h8};
    end else begin
      sync1 <= {cmp_above, spi_cs_n, normal_mode, vdd_present, frame_tgl};
      sync2 <= sync1;
    end
  end

  wire [21:0] cmp_q      = sync2[25:4];
  wire        cs_q       = sync2[3];
  wire        normal_q   = sync2[2];
  wire        vdd_q      = sync2[1];
  wire        tgl_q      = sync2[0];
  wire        cs_rise    = cs_q & ~cs_prev;
  wire        cs_fall    = ~cs_q & cs_prev;

  // Edge history of synchronised levels.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_prev <= 22'h000000;
      cs_prev  <= 1'b1;
      tgl_seen <= 1'b0;
    end else begin
      cmp_prev <= cmp_q;
      cs_prev  <= cs_q;
      if (cs_rise) begin
        tgl_seen <= tgl_q;
      end
    end
  end

  // ****************************************************************
  // Command capture and decode.
  // ****************************************************************

  // The received word is only read after chip select has risen and the
  // link clock has stopped, so it is still while it crosses. A frame with
  // no clock edges (the calibration pulse) leaves the toggle alone and is
  // never taken as a fresh command.
  wire       new_frame  = tgl_q ^ tgl_seen;
  wire       prog_ok    = normal_q & vdd_q;
  wire       cmd_take   = cs_rise & new_frame & rx_complete & prog_ok;
  swc_cmd_t  cmd;
  assign cmd = rx_word;

  wire hit_tmr_sp = cmd_take && cmd.code == CMD_TMR_SP;
  wire hit_tmr_sg = cmd_take && cmd.code == CMD_TMR_SG;
  wire hit_hz_sp  = cmd_take && cmd.code == CMD_HZ_SP;
  wire hit_hz_sg  = cmd_take && cmd.code == CMD_HZ_SG;
  wire hit_analog = cmd_take && cmd.code == CMD_ANALOG;
  wire hit_cal    = cmd_take && cmd.code == CMD_CAL;
  wire hit_reset  = cmd_take && cmd.code == CMD_RESET;

  // Next register values; the reset command outranks every other hit,
  // though only one code can arrive per frame.
  wire [7:0] next_tmr_sp =
    hit_reset  ? RST_TMR_SP :
    hit_tmr_sp ? cmd.arg[7:0] : timer_enable_programmable;
  wire [13:0] next_tmr_sg =
    hit_reset  ? RST_TMR_SG :
    hit_tmr_sg ? cmd.arg[13:0] : timer_enable_ground;
  wire [7:0] next_hz_sp =
    hit_reset ? RST_HZ_SP :
    hit_hz_sp ? cmd.arg[7:0] : high_z_programmable;
  wire [13:0] next_hz_sg =
    hit_reset ? RST_HZ_SG :
    hit_hz_sg ? cmd.arg[13:0] : high_z_ground;
  wire [6:0] next_analog =
    hit_reset  ? RST_ANALOG :
    hit_analog ? cmd.arg[6:0] : analog_channel_select;

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************

  // Written by the master at any time in Normal mode; the decode above
  // already holds them when programming is not allowed.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_enable_programmable <= RST_TMR_SP;
      timer_enable_ground       <= RST_TMR_SG;
      high_z_programmable       <= RST_HZ_SP;
      high_z_ground             <= RST_HZ_SG;
      analog_channel_select     <= RST_ANALOG;
    end else begin
      timer_enable_programmable <= next_tmr_sp;
      timer_enable_ground       <= next_tmr_sg;
      high_z_programmable       <= next_hz_sp;
      high_z_ground             <= next_hz_sg;
      analog_channel_select     <= next_analog;
    end
  end

  // ****************************************************************
  // Calibration of the time base.
  // ****************************************************************

  // The calibration command arms the measurement; the next chip-select low
  // pulse is counted in mclk cycles. Other link lines are assumed still.
  always_comb begin
    next_cal_state = cal_state;
    case (cal_state)
      CAL_IDLE: begin
        if (hit_cal) begin
          next_cal_state = CAL_ARMED;
        end
      end
      CAL_ARMED: begin
        if (hit_reset) begin
          next_cal_state = CAL_IDLE;
        end else if (cs_fall) begin
          next_cal_state = CAL_MEASURE;
        end
      end
      CAL_MEASURE: begin
        if (cs_rise) begin
          next_cal_state = CAL_IDLE;
        end
      end
      default: begin
        next_cal_state = CAL_IDLE;
      end
    endcase
  end

  // Pulse length divided by its nominal microsecond count gives cycles
  // per microsecond; a zero result is discarded so the tick never stalls.
  wire [15:0] cal_quot  = {1'b0, cal_cnt[CAL_SHIFT +: 15]};
  wire        cal_store = (cal_state == CAL_MEASURE) && cs_rise && (cal_quot != 16'h0000);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_state      <= CAL_IDLE;
      cal_cnt        <= 24'h000000;
      time_base_trim <= TICK_CYCLES;
    end else begin
      cal_state <= next_cal_state;
      if (cal_state != CAL_MEASURE) begin
        cal_cnt <= 24'h000001; // The entry cycle belongs to the pulse too.
      end else if (cal_cnt != 24'hffffff) begin
        cal_cnt <= cal_cnt + 24'h000001;
      end
      if (hit_reset) begin
        time_base_trim <= TICK_CYCLES;
      end else if (cal_store) begin
        time_base_trim <= cal_quot;
      end
    end
  end

  // ****************************************************************
  // Microsecond time base.
  // ****************************************************************

  // Every wetting timer runs from this tick, so trimming it trims them all.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 16'h0000;
      us_tick  <= 1'b0;
    end else if (tick_cnt >= time_base_trim - 16'h0001) begin
      tick_cnt <= 16'h0000;
      us_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      us_tick  <= 1'b0;
    end
  end

  // ****************************************************************
  // Wetting timers.
  // ****************************************************************
  wire [21:0] tmr_en   = {timer_enable_programmable, timer_enable_ground};
  wire [21:0] crossing = cmp_q ^ cmp_prev;

  // One timer per input; indices 0..13 are ground, 14..21 programmable.
  for (genvar g = 0; g < NUM_IN; g++) begin : g_wet
    swc_wet_timer #(
      .WET_TICKS (WET_TICKS)
    ) u_timer (
      .clk     (mclk),
      .rst     (sys_rst),
      .tick    (us_tick),
      .restart (crossing[g]),
      .enable  (tmr_en[g]),
      .expired (wet_expired[g])
    );
  end

  // ****************************************************************
  // Analog channel decode.
  // ****************************************************************
  wire [4:0]  chan       = analog_channel_select[CHAN_MSB:0];
  wire [1:0]  cur_sel    = analog_channel_select[CUR_SEL_LSB +: 2];
  wire        chan_valid = (chan != 5'h00) && (chan <= CHAN_LAST);
  wire [21:0] sel_onehot = chan_valid ? (22'h000001 << (chan - 5'h01)) : 22'h000000;
  wire        an_16ma    = (cur_sel == CUR_16MA);
  wire        an_2ma     = (cur_sel == CUR_2MA);

  // ****************************************************************
  // Per-input current drive.
  // ****************************************************************

  // A floating input keeps its comparator; only the current source is cut.
  wire [21:0] hz_reg    = {high_z_programmable, high_z_ground};
  wire [21:0] normal_hz = hz_reg;
  wire [21:0] normal_16 = ~hz_reg & ~wet_expired;
  wire [21:0] normal_2  = ~hz_reg & wet_expired;

  // The analog channel takes its current from the analog command; a
  // disallowed select pattern leaves it floating.
  wire [21:0] an_mask    = an_16ma ? sel_onehot : 22'h000000;
  wire [21:0] an_mask_2  = an_2ma ? sel_onehot : 22'h000000;
  wire [21:0] next_hz    = (normal_hz & ~sel_onehot) |
                           (sel_onehot & ~an_mask & ~an_mask_2);
  wire [21:0] next_16    = (normal_16 & ~sel_onehot) | an_mask;
  wire [21:0] next_2     = (normal_2 & ~sel_onehot) | an_mask_2;

  // Switch-to-battery inputs normally pull down; an analog channel always
  // pulls up. Ground inputs are pull-up by construction.
  wire [7:0]  next_pull  = ~prog_to_battery | sel_onehot[21:14];

  // Outputs registered so the analog front end sees no decode glitches.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      drive.high_z          <= {RST_HZ_SP, RST_HZ_SG};
      drive.cur_16ma        <= 22'h000000;
      drive.cur_2ma         <= 22'h000000;
      drive.pull_up         <= 8'h00;
      analog_output_pin_sel <= 5'h00;
      analog_output_pin_en  <= 1'b0;
    end else begin
      drive.high_z          <= next_hz;
      drive.cur_16ma        <= next_16;
      drive.cur_2ma         <= next_2;
      drive.pull_up         <= next_pull;
      analog_output_pin_sel <= chan_valid ? chan : 5'h00;
      analog_output_pin_en  <= chan_valid;
    end
  end

  // ****************************************************************
  // Status word for the next response.
  // ****************************************************************

  // Closed means below threshold, except switch-to-battery inputs. Comparators
  // remain live whether or not the input floats.
  wire [21:0] closed = {cmp_q[21:14] ^ ~prog_to_battery, ~cmp_q[13:0]};

  // Frozen while chip select is low so the link domain reads a still word;
  // the master must leave three mclk cycles after the fall before clocking.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_word <= 24'h000000;
    end else if (cs_q) begin
      status_word <= {2'b00, closed & ~sel_onehot};
    end
  end

endmodule : swc_top

// file: sim/swc_top_assertions.sv
// Checker for the configuration top, bound to its ports from the bench.
// Assumes one mclk domain and an active-high asynchronous reset.
`timescale 1ns/100ps
module swc_top_assertions
  import swc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        spi_cs_n,
  input wire logic        spi_so_oe,
  input wire logic        normal_mode,
  input wire logic        vdd_present,
  input wire swc_drive_t  drive,
  input wire logic [4:0]  analog_output_pin_sel,
  input wire logic        analog_output_pin_en,
  input wire logic [15:0] time_base_trim
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Power-on state, then exclusivity of the drive levels.
  reset_state_a: assert property (
    $past(sys_rst) |-> drive.high_z == 22'h3fffff && !analog_output_pin_en
      && time_base_trim == TICK_CYCLES)
    else $error("outputs not at power-on state");
  float_no_cur_a: assert property (
    (drive.high_z & (drive.cur_16ma | drive.cur_2ma)) == 22'h0)
    else $error("floating input sources current");
  one_level_a: assert property (
    (drive.cur_16ma & drive.cur_2ma) == 22'h0)
    else $error("two current levels on one input");
  // The enable alone would not reveal a wrong channel decode.
  chan_enable_a: assert property (
    analog_output_pin_en == (analog_output_pin_sel != 5'h00))
    else $error("analog enable disagrees with channel");
  analog_pull_a: assert property (
    analog_output_pin_en && analog_output_pin_sel > 5'h0e && $stable(analog_output_pin_sel)
    |-> drive.pull_up[analog_output_pin_sel - 5'h0f])
    else $error("analog input not pulled up");
  so_enable_a: assert property (
    spi_so_oe == !spi_cs_n)
    else $error("data out enable wrong");
  // Trim only moves once a frame or pulse has closed; settings only after Normal mode with supply present.
  trim_at_end_a: assert property (
    $changed(time_base_trim) |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("trim moved inside a pulse");
  mode_gate_a: assert property (
    $changed(analog_output_pin_sel) || $changed(drive.high_z)
    |-> $past(normal_mode, 4) && $past(vdd_present, 4))
    else $error("setting changed outside Normal mode");
endmodule : swc_top_assertions

// file: sim/swc_spi_master.sv
// Link master model: 24-bit frames MSB first and a calibration pulse.
// Assumes the bench calls its tasks just after a falling mclk edge.
`timescale 1ns/100ps
module swc_spi_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic so
);
  // Idle: link clock parked low, select high.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // 15 ns link clock runs only inside a frame; so is taken before each rise.
  task automatic send(input logic [23:0] word, output logic [23:0] resp);
    cs_n = 1'b0;
    #40;
    for (int i = 23; i >= 0; i--) begin
      mosi = word[i];
      #7.5;
      resp[i] = so;
      sclk = 1'b1;
      #7.5;
      sclk = 1'b0;
    end
    #10;
    cs_n = 1'b1;
    // A released data line must not look like a held bit.
    mosi = ~mosi;
    #80;
  endtask : send

  // Select low alone while all other lines hold still.
  task automatic cal(input int len);
    cs_n = 1'b0;
    #(len);
    cs_n = 1'b1;
    #80;
  endtask : cal
endmodule : swc_spi_master

// file: sim/swc_top_tb.sv
// Bench for the switch-input configuration top, driven over the link.
// Assumes the master model and the checker are compiled before it.
`timescale 1ns/100ps
module swc_top_tb;
  import swc_pkg::*;
  logic        mclk, sys_rst, spi_sclk, spi_cs_n, spi_mosi, spi_so;
  logic        spi_so_oe, normal_mode, vdd_present, analog_output_pin_en;
  logic [21:0] cmp_above;
  logic [7:0]  prog_to_battery;
  swc_drive_t  drive;
  logic [4:0]  analog_output_pin_sel;
  logic [15:0] time_base_trim;
  logic [23:0] so_word;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [4:0]  chans [4] = '{5'h01, 5'h0e, 5'h16, 5'h00};

  // A short wetting count keeps each timer run near 20 us.
  swc_top #(.WET_TICKS(15'h0014)) swc_top_inst (
    .mclk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_so, .spi_so_oe,
    .normal_mode, .vdd_present, .cmp_above, .prog_to_battery, .drive,
    .analog_output_pin_sel, .analog_output_pin_en, .time_base_trim);
  swc_spi_master swc_spi_master_inst (
    .sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi), .so(spi_so));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [23:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One frame, then room for the resync and the two-cycle update.
  task automatic cmd(input logic [7:0] code, input logic [15:0] arg);
    swc_spi_master_inst.send({code, arg}, so_word);
    repeat (4) @(negedge mclk);
  endtask : cmd

  task automatic us(input int n);
    repeat (n * 100) @(negedge mclk);
  endtask : us

  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // ****
  // Stimulus.
  // ****
  initial begin
    sys_rst = 1'b1;
    normal_mode = 1'b1;
    vdd_present = 1'b1;
    cmp_above = '0;
    prog_to_battery = 8'hff;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    chk("high_z", drive.high_z, 22'h3fffff);
    cmd(CMD_HZ_SP, 16'hff00);
    cmd(CMD_HZ_SG, 16'hc000);
    chk("high_z", drive.high_z, 22'h0);
    cmp_above = '1;
    us(5);
    chk("wet", drive.cur_16ma, 22'h3fffff);
    us(25);
    chk("sustain", drive.cur_2ma, 22'h3fffff);
    cmd(CMD_TMR_SP, 16'h00f0);
    cmd(CMD_TMR_SG, 16'hc00f);
    cmp_above = '0;
    us(30);
    chk("timed", drive.cur_2ma, 22'h3c000f);
    chk("untimed", drive.cur_16ma, 22'h03fff0);
    cmd(8'h05, 16'h00ff);
    normal_mode = 1'b0;
    cmd(CMD_HZ_SP, 16'h00ff);
    normal_mode = 1'b1;
    chk("ignored", drive.high_z, 22'h0);
    vdd_present = 1'b0;
    cmd(CMD_HZ_SG, 16'h3fff);
    vdd_present = 1'b1;
    chk("no_supply", drive.high_z, 22'h0);
    for (int k = 0; k < 4; k++) begin
      cmd(CMD_ANALOG, {9'h1ff, 2'(k), 5'h0f});
      chk("pull_up", drive.pull_up[0], 1'b1);
      chk("cur16", drive.cur_16ma[14], k == 2);
      chk("cur2", drive.cur_2ma[14], k == 1);
      chk("float", drive.high_z[14], k == 0 || k == 3);
    end
    cmd(CMD_ANALOG, 16'h0041);
    cmd(8'h00, 16'h0000);
    chk("status", so_word, 24'h003ffe);
    foreach (chans[i]) begin
      cmd(CMD_ANALOG, {11'h0, chans[i]});
      chk("chan", {analog_output_pin_en, analog_output_pin_sel}, {chans[i] != 0, chans[i]});
    end
    // A 563.2 us pulse stands for a fast oscillator: 56320 >> 9 = 110.
    cmd(CMD_CAL, 16'hffff);
    swc_spi_master_inst.cal(563200);
    repeat (8) @(negedge mclk);
    chk("trim", time_base_trim, 16'h006e);
    cmd(CMD_RESET, 16'h5a5a);
    chk("high_z", drive.high_z, 22'h3fffff);
    chk("trim", time_base_trim, TICK_CYCLES);
    cmp_above = 22'h03c000;
    repeat (4) @(negedge mclk);
    cmd(8'h00, 16'h0000);
    chk("status", so_word, 24'h03ffff);
    wrap_up();
  end

  // The run takes near 635 us; a hang is cut off well past that.
  initial begin
    #1_000_000;
    bad_count++;
    wrap_up();
  end
endmodule : swc_top_tb

bind swc_top swc_top_assertions swc_top_assertions_inst (
  .mclk, .sys_rst, .spi_cs_n, .spi_so_oe, .normal_mode, .vdd_present, .drive,
  .analog_output_pin_sel, .analog_output_pin_en, .time_base_trim);
